// ===== rtl/energy_cfg_pkg.sv
// Constants for the energy manager configuration and status register bank
package energy_cfg_pkg;
  // Register offsets
  localparam logic [3:0] ADDR_GAUGE3  = 4'h1;
  localparam logic [3:0] ADDR_GAUGE2  = 4'h2;
  localparam logic [3:0] ADDR_GAUGE1  = 4'h3;
  localparam logic [3:0] ADDR_GAUGE0  = 4'h4;
  localparam logic [3:0] ADDR_CAPV    = 4'h5;
  localparam logic [3:0] ADDR_TARGET  = 4'h6;
  localparam logic [3:0] ADDR_PROFHI  = 4'h7;
  localparam logic [3:0] ADDR_MODECMD = 4'h8;
  localparam logic [3:0] ADDR_FIXEND  = 4'h9;
  localparam logic [3:0] ADDR_CHGOUT  = 4'hA;
  localparam logic [3:0] ADDR_EWCFG   = 4'hB;
  localparam logic [3:0] ADDR_MARGIN  = 4'hD;
  // Field positions
  localparam int ICH_LSB    = 5;
  localparam int HIZ_BIT    = 4;
  localparam int EWEN_BIT   = 4;
  localparam int EWTH_LSB   = 0;
  localparam int PROFHI_LSB = 0;
  localparam int PROFLO_LSB = 4;
  localparam int FIXEND_LSB = 4;
  localparam int MARGIN_LSB = 0;
  // Charge current codes
  localparam logic [2:0] ICH_2MA   = 3'h0;
  localparam logic [2:0] ICH_4MA   = 3'h1;
  localparam logic [2:0] ICH_8MA   = 3'h2;
  localparam logic [2:0] ICH_16MA  = 3'h3;
  localparam logic [2:0] ICH_EMERG = 3'h4;
  // Reset values and threshold limit
  localparam logic [2:0] ICH_RESET    = ICH_8MA;
  localparam logic [3:0] EWTH_RESET   = 4'h0;
  localparam logic [3:0] EWTH_MAX     = 4'h9;
  localparam logic [1:0] MARGIN_RESET = 2'h3;
  localparam logic [3:0] FIXEND_RESET = 4'h0;
  localparam logic [5:0] PROF_FIXED   = 6'h00;
  localparam logic [7:0] READ_ZERO    = 8'h00;
  // Capacitor codes matching the warning thresholds 2.4 V .. 4.8 V
  localparam logic [4:0] EW_CAP_BASE  = 5'h04;
  // Default low time of the ready pulse, in clock cycles
  localparam int EW_PULSE_DEFAULT = 16;
  // Ready pulse machine, one-hot
  typedef enum logic [1:0] {
    RDY_IDLE  = 2'b01,
    RDY_PULSE = 2'b10
  } rdy_state_e;
endpackage

// ===== rtl/energy_manager_regs.sv
// Configuration and status register bank of the battery energy manager
`timescale 1ns/1ns
module energy_manager_regs #(
  parameter int EW_PULSE_CYCLES = energy_cfg_pkg::EW_PULSE_DEFAULT
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Register port from the serial transport
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  // Device state and measurement inputs
  input  wire logic       chargeStart,
  input  wire logic       inCharge,
  input  wire logic       inActive,
  input  wire logic       inStandby,
  input  wire logic [4:0] capCodeIn,
  input  wire logic [4:0] targetCodeIn,
  input  wire logic       energyValid,
  input  wire logic [7:0] energyStep,
  // Configuration outputs
  output logic      [2:0] chargeCurrentCode,
  output logic      [3:0] warnThreshCode,
  output logic            warnEnable,
  output logic            outputHighZ,
  output logic      [5:0] profileNumber,
  output logic            optimizeEnable,
  output logic      [1:0] marginCode,
  output logic      [3:0] fixedEndCode,
  output logic            fixedEndApply,
  // Status outputs
  output logic            warningFlag,
  output logic            readyPin_n
);

  localparam int PCW = $clog2(EW_PULSE_CYCLES + 1);
  localparam logic [PCW-1:0] PULSE_LOAD = PCW'(EW_PULSE_CYCLES - 1);

  logic [2:0]  ich_q, ich_d;
  logic        hiz_q, hiz_d;
  logic [3:0]  ewTh_q, ewTh_d;
  logic        ewEn_q, ewEn_d;
  logic [1:0]  profHi_q, profHi_d;
  logic [3:0]  profLo_q, profLo_d;
  logic [1:0]  margin_q, margin_d;
  logic [3:0]  fixEnd_q, fixEnd_d;
  logic [31:0] energy_q, energy_d;
  logic [4:0]  capCode_q, capCode_d;
  logic [4:0]  target_q, target_d;
  logic [7:0]  rdData_q, rdData_d;
  logic        hizOut_q, hizOut_d;
  logic        warn_q, warn_d;
  logic        optEn_q, optEn_d;
  logic        fixApply_q, fixApply_d;
  energy_cfg_pkg::rdy_state_e rdy_q, rdy_d;
  logic [PCW-1:0] pulseCnt_q, pulseCnt_d;
  logic        rdyN_q, rdyN_d;
  logic [4:0]  ewCapCode;
  logic        capBelow;

  // Threshold code to capacitor code; codes above the table saturate
  always_comb begin
    if (ewTh_q > energy_cfg_pkg::EWTH_MAX) begin
      ewCapCode = energy_cfg_pkg::EW_CAP_BASE + 5'(energy_cfg_pkg::EWTH_MAX);
    end else begin
      ewCapCode = energy_cfg_pkg::EW_CAP_BASE + {1'b0, ewTh_q};
    end
    capBelow = capCode_q < ewCapCode;
  end

  // Configuration writes, decoded by address
  always_comb begin
    ich_d    = ich_q;
    hiz_d    = hiz_q;
    ewTh_d   = ewTh_q;
    ewEn_d   = ewEn_q;
    profHi_d = profHi_q;
    profLo_d = profLo_q;
    margin_d = margin_q;
    fixEnd_d = fixEnd_q;
    if (regWrite) begin
      if (regAddr == energy_cfg_pkg::ADDR_CHGOUT) begin
        if (regWrData[energy_cfg_pkg::ICH_LSB +: 3] <= energy_cfg_pkg::ICH_EMERG) begin
          ich_d = regWrData[energy_cfg_pkg::ICH_LSB +: 3];
        end
        hiz_d = regWrData[energy_cfg_pkg::HIZ_BIT];
      end else if (regAddr == energy_cfg_pkg::ADDR_EWCFG) begin
        ewTh_d = regWrData[energy_cfg_pkg::EWTH_LSB +: 4];
        ewEn_d = regWrData[energy_cfg_pkg::EWEN_BIT];
      end else if (regAddr == energy_cfg_pkg::ADDR_PROFHI) begin
        profHi_d = regWrData[energy_cfg_pkg::PROFHI_LSB +: 2];
      end else if (regAddr == energy_cfg_pkg::ADDR_MODECMD) begin
        profLo_d = regWrData[energy_cfg_pkg::PROFLO_LSB +: 4];
      end else if (regAddr == energy_cfg_pkg::ADDR_MARGIN) begin
        margin_d = regWrData[energy_cfg_pkg::MARGIN_LSB +: 2];
      end else if (regAddr == energy_cfg_pkg::ADDR_FIXEND) begin
        fixEnd_d = regWrData[energy_cfg_pkg::FIXEND_LSB +: 4];
      end
    end
  end

  // Fields hold until rewritten; only defined bits are stored
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ich_q    <= energy_cfg_pkg::ICH_RESET;
      hiz_q    <= 1'b0;
      ewTh_q   <= energy_cfg_pkg::EWTH_RESET;
      ewEn_q   <= 1'b0;
      profHi_q <= 2'h0;
      profLo_q <= 4'h0;
      margin_q <= energy_cfg_pkg::MARGIN_RESET;
      fixEnd_q <= energy_cfg_pkg::FIXEND_RESET;
    end else begin
      ich_q    <= ich_d;
      hiz_q    <= hiz_d;
      ewTh_q   <= ewTh_d;
      ewEn_q   <= ewEn_d;
      profHi_q <= profHi_d;
      profLo_q <= profLo_d;
      margin_q <= margin_d;
      fixEnd_q <= fixEnd_d;
    end
  end

  // Status capture: gauge, capacitor code, target, derived outputs
  always_comb begin
    energy_d   = energy_q;
    capCode_d  = capCode_q;
    target_d   = target_q;
    // charge start clears the gauge, a same-cycle step is dropped
    if (chargeStart) begin
      energy_d = 32'h0000_0000;
    end else if (energyValid) begin
      energy_d = energy_q + {24'h00_0000, energyStep};
    end
    // standby leakage is deliberately not tracked
    if (inCharge || inActive) begin
      capCode_d = capCodeIn;
    end
    // target latched once per charge cycle
    if (chargeStart) begin
      target_d = targetCodeIn;
    end
    // high impedance only applies in standby or active
    hizOut_d   = hiz_q && (inStandby || inActive);
    optEn_d    = {profHi_q, profLo_q} != energy_cfg_pkg::PROF_FIXED;
    // fixed end point only in fixed mode
    fixApply_d = {profHi_q, profLo_q} == energy_cfg_pkg::PROF_FIXED;
  end

  // Early warning flag and ready pulse machine
  always_comb begin
    warn_d     = warn_q;
    rdy_d      = rdy_q;
    pulseCnt_d = pulseCnt_q;
    rdyN_d     = 1'b1;
    if (chargeStart) begin
      warn_d = 1'b0;
    end
    case (rdy_q)
      energy_cfg_pkg::RDY_IDLE: begin
        // detection only while enabled and active
        if (ewEn_q && inActive && capBelow && !warn_q && !chargeStart) begin
          warn_d     = 1'b1;
          rdy_d      = energy_cfg_pkg::RDY_PULSE;
          pulseCnt_d = PULSE_LOAD;
          rdyN_d     = 1'b0;
        end
      end
      energy_cfg_pkg::RDY_PULSE: begin
        rdyN_d = 1'b0;
        if (pulseCnt_q == '0) begin
          rdy_d  = energy_cfg_pkg::RDY_IDLE;
          rdyN_d = 1'b1;
        end else begin
          pulseCnt_d = pulseCnt_q - PCW'(1);
        end
      end
      default: begin
        rdy_d = energy_cfg_pkg::RDY_IDLE;
      end
    endcase
  end

  // Read data mux; write-only and unmapped offsets read zero
  always_comb begin
    rdData_d = rdData_q;
    if (regRead) begin
      // gauge bytes, most significant at the lowest offset
      if (regAddr == energy_cfg_pkg::ADDR_GAUGE3) begin
        rdData_d = energy_q[31:24];
      end else if (regAddr == energy_cfg_pkg::ADDR_GAUGE2) begin
        rdData_d = energy_q[23:16];
      end else if (regAddr == energy_cfg_pkg::ADDR_GAUGE1) begin
        rdData_d = energy_q[15:8];
      end else if (regAddr == energy_cfg_pkg::ADDR_GAUGE0) begin
        rdData_d = energy_q[7:0];
      end else if (regAddr == energy_cfg_pkg::ADDR_CAPV) begin
        // five-bit code in the low bits
        rdData_d = {3'h0, capCode_q};
      end else if (regAddr == energy_cfg_pkg::ADDR_TARGET) begin
        // five-bit code in the low bits
        rdData_d = {3'h0, target_q};
      end else begin
        rdData_d = energy_cfg_pkg::READ_ZERO;
      end
    end
  end

  // Status and output registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      energy_q   <= 32'h0000_0000;
      capCode_q  <= 5'h00;
      target_q   <= 5'h00;
      rdData_q   <= energy_cfg_pkg::READ_ZERO;
      hizOut_q   <= 1'b0;
      optEn_q    <= 1'b0;
      fixApply_q <= 1'b1;
      warn_q     <= 1'b0;
      rdy_q      <= energy_cfg_pkg::RDY_IDLE;
      pulseCnt_q <= '0;
      rdyN_q     <= 1'b1;
    end else begin
      energy_q   <= energy_d;
      capCode_q  <= capCode_d;
      target_q   <= target_d;
      rdData_q   <= rdData_d;
      hizOut_q   <= hizOut_d;
      optEn_q    <= optEn_d;
      fixApply_q <= fixApply_d;
      warn_q     <= warn_d;
      rdy_q      <= rdy_d;
      pulseCnt_q <= pulseCnt_d;
      rdyN_q     <= rdyN_d;
    end
  end

  // Outputs straight from flip-flops
  assign regRdData         = rdData_q;
  assign chargeCurrentCode = ich_q;
  assign warnThreshCode    = ewTh_q;
  assign warnEnable        = ewEn_q;
  assign outputHighZ       = hizOut_q;
  assign profileNumber     = {profHi_q, profLo_q};
  assign optimizeEnable    = optEn_q;
  assign marginCode        = margin_q;
  assign fixedEndCode      = fixEnd_q;
  assign fixedEndApply     = fixApply_q;
  assign warningFlag       = warn_q;
  assign readyPin_n        = rdyN_q;

  a_ich_defined: assert property (@(posedge core_clk) disable iff (!reset_n)
    ich_q <= energy_cfg_pkg::ICH_EMERG) else $error("charge code undefined");
  a_ich_reject: assert property (@(posedge core_clk) disable iff (!reset_n)
    regWrite && regAddr == energy_cfg_pkg::ADDR_CHGOUT && regWrData[7:5] > 3'h4
    |=> $stable(ich_q)) else $error("undefined charge code taken");
  a_ewth_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    regWrite && regAddr == energy_cfg_pkg::ADDR_EWCFG
    |=> ewTh_q == $past(regWrData[3:0]) && ewEn_q == $past(regWrData[4]))
    else $error("warning config not stored");
  a_warn_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(warn_q) |-> $past(ewEn_q) && $past(inActive)) else $error("warning while off");
  a_hiz_state: assert property (@(posedge core_clk) disable iff (!reset_n)
    outputHighZ |-> $past(hiz_q) && ($past(inStandby) || $past(inActive)))
    else $error("high impedance out of state");
  a_opt_profile: assert property (@(posedge core_clk) disable iff (!reset_n)
    ##1 optEn_q == ($past(profileNumber) != 6'h00) && fixApply_q == !optEn_q)
    else $error("optimize enable wrong");
  a_gauge_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    regRead && regAddr == energy_cfg_pkg::ADDR_GAUGE3 |=> regRdData == $past(energy_q[31:24]))
    else $error("gauge MSB wrong");
  a_gauge_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    chargeStart |=> energy_q == 32'h0 && !warn_q) else $error("charge start did not clear");
  a_cap_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !inCharge && !inActive |=> $stable(capCode_q)) else $error("capacitor code moved");
  a_ready_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(warn_q) |-> !readyPin_n ##EW_PULSE_CYCLES readyPin_n)
    else $error("ready pulse length wrong");
  a_status_ro: assert property (@(posedge core_clk) disable iff (!reset_n)
    regWrite && regAddr == energy_cfg_pkg::ADDR_TARGET && !chargeStart |=> $stable(target_q))
    else $error("status register written");

endmodule

// ===== sim/host_model.sv
// Host microcontroller model driving the register port of the bank
`timescale 1ns/1ns
module host_model (
  // Clock
  input  wire logic       core_clk,
  // Register port
  output logic            regWrite,
  output logic            regRead,
  output logic      [3:0] regAddr,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData
);
  // Idle port at time zero
  initial begin
    regWrite  = 1'b0;
    regRead   = 1'b0;
    regAddr   = 4'h0;
    regWrData = 8'h00;
  end

  // One write strobe; data goes to its inverse once released
  task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [7:0] sent);
    sent = d;
    if (a == energy_cfg_pkg::ADDR_CHGOUT && d[7:5] > 3'h4) begin
      sent[7] = 1'b0;
    end
    @(posedge core_clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= sent;
    @(posedge core_clk);
    regWrite  <= 1'b0;
    regWrData <= ~sent;
  endtask

  // One read strobe; data is registered, taken a cycle later
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    d = regRdData;
  endtask
endmodule

// ===== sim/test_energy_manager_config_status_regs.sv
// Self-checking bench for the energy manager register bank
`timescale 1ns/1ns
module test_energy_manager_config_status_regs;
  localparam int WATCHDOG_CYCLES = 20000;
  logic       core_clk, reset_n, regWrite, regRead;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, sent, rdv;
  logic       chargeStart, inCharge, inActive, inStandby, energyValid;
  logic [4:0] capCodeIn, targetCodeIn;
  logic [7:0] energyStep;
  logic [2:0] chargeCurrentCode;
  logic [3:0] warnThreshCode, fixedEndCode;
  logic [5:0] profileNumber;
  logic [1:0] marginCode;
  logic       warnEnable, outputHighZ, optimizeEnable, fixedEndApply;
  logic       warningFlag, readyPin_n;
  int         ich, thr, ewen, hiz, prof, margin, fixend, cap, target, warn;
  int         error_cnt, n_compared, k, n, seedVal;
  int unsigned gauge;

  host_model host (.core_clk(core_clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));

  energy_manager_regs dut (.core_clk(core_clk), .reset_n(reset_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .chargeStart(chargeStart), .inCharge(inCharge), .inActive(inActive),
    .inStandby(inStandby), .capCodeIn(capCodeIn), .targetCodeIn(targetCodeIn),
    .energyValid(energyValid), .energyStep(energyStep),
    .chargeCurrentCode(chargeCurrentCode), .warnThreshCode(warnThreshCode),
    .warnEnable(warnEnable), .outputHighZ(outputHighZ), .profileNumber(profileNumber),
    .optimizeEnable(optimizeEnable), .marginCode(marginCode),
    .fixedEndCode(fixedEndCode), .fixedEndApply(fixedEndApply),
    .warningFlag(warningFlag), .readyPin_n(readyPin_n));

  // Free-running 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Compare one value and count it
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Expected readback; status values reach the bus zero-extended
  function automatic int exp_rd(input int a);
    if (a >= 1 && a <= 4) return (gauge >> (8 * (4 - a))) & 255;
    if (a == 5) return cap;
    if (a == 6) return target;
    return 0;
  endfunction

  // Extra edge lets the derived outputs settle
  task automatic chk_cfg();
    @(posedge core_clk);
    #1;
    chk("ich", chargeCurrentCode, ich);
    chk("thr", warnThreshCode, thr);
    chk("ewen", warnEnable, ewen);
    chk("hiz", outputHighZ, hiz & (inStandby | inActive));
    chk("prof", profileNumber, prof);
    chk("opt", optimizeEnable, prof != 0);
    chk("margin", marginCode, margin);
    chk("fixend", fixedEndCode, fixend);
    chk("fixapply", fixedEndApply, prof == 0);
    chk("flag", warningFlag, warn);
    chk("ready", readyPin_n, 1);
  endtask

  // Host write mirrored into the model
  task automatic w(input logic [3:0] a, input logic [7:0] d);
    host.wr(a, d, sent);
    case (a)
      energy_cfg_pkg::ADDR_CHGOUT: begin
        ich = sent[7:5];
        hiz = sent[4];
      end
      energy_cfg_pkg::ADDR_EWCFG: begin
        thr = sent[3:0];
        ewen = sent[4];
      end
      energy_cfg_pkg::ADDR_PROFHI: prof = sent[1:0] * 16 + prof % 16;
      energy_cfg_pkg::ADDR_MODECMD: prof = (prof / 16) * 16 + sent[7:4];
      energy_cfg_pkg::ADDR_FIXEND: fixend = sent[7:4];
      energy_cfg_pkg::ADDR_MARGIN: margin = sent[1:0];
      default: ;
    endcase
    chk_cfg();
  endtask

  // Device state levels and converter code
  task automatic st(input logic c, input logic a, input logic s, input logic [4:0] v);
    @(posedge core_clk);
    inCharge  <= c;
    inActive  <= a;
    inStandby <= s;
    capCodeIn <= v;
    repeat (2) @(posedge core_clk);
    if (c | a) cap = v;
  endtask

  // New charge cycle with a fresh end-of-charge code
  task automatic charge(input logic [4:0] t);
    @(posedge core_clk);
    chargeStart  <= 1'b1;
    targetCodeIn <= t;
    @(posedge core_clk);
    chargeStart  <= 1'b0;
    targetCodeIn <= ~t;
    gauge = 0;
    target = t;
    warn = 0;
  endtask

  // Read a range of addresses against the model
  task automatic rd_all(input int lo, input int hi);
    for (int a = lo; a <= hi; a++) begin
      host.rd(a[3:0], rdv);
      chk("rd", rdv, exp_rd(a));
    end
  endtask

  initial begin
    repeat (WATCHDOG_CYCLES) @(posedge core_clk);
    error_cnt++;
    conclude();
  end

  initial begin
    {reset_n, chargeStart, inCharge, inActive, inStandby, energyValid} = 6'h00;
    {capCodeIn, targetCodeIn, energyStep} = 18'h00000;
    {ich, thr, ewen, hiz, prof, margin, fixend} = {32'd2, 32'd0, 32'd0, 32'd0, 32'd0, 32'd3, 32'd0};
    {cap, target, warn, gauge, error_cnt, n_compared} = 0;
    seedVal = $urandom(77472);
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    chk_cfg();
    rd_all(7, 15);
    $display("test defaults done");
    // Every defined charge current code
    for (k = 0; k <= 4; k++) w(energy_cfg_pkg::ADDR_CHGOUT, {k[2:0], 5'h00});
    // Random writes include status and unmapped offsets
    for (k = 0; k < 60; k++) w(4'($urandom_range(15)), 8'($urandom_range(255)));
    // Status registers must not have taken any of the writes
    rd_all(1, 6);
    $display("test writes done");
    w(energy_cfg_pkg::ADDR_EWCFG, 8'h00);
    for (k = 0; k < 8; k++) begin
      w(energy_cfg_pkg::ADDR_CHGOUT, {3'h2, k[0], 4'h0});
      st(1'b0, k[2], k[1], 5'h07);
      chk_cfg();
    end
    $display("test output mode done");
    st(1'b1, 1'b0, 1'b0, 5'h0B);
    charge(5'($urandom_range(31)));
    // Steps of at least 128 guarantee a carry into the third byte
    for (k = 0; k < 600; k++) begin
      n = 128 + $urandom_range(127);
      @(posedge core_clk);
      energyValid <= 1'b1;
      energyStep  <= n[7:0];
      @(posedge core_clk);
      energyValid <= 1'b0;
      gauge += n;
    end
    rd_all(0, 15);
    st(1'b0, 1'b0, 1'b1, 5'h03);
    host.rd(energy_cfg_pkg::ADDR_CAPV, rdv);
    chk("capv", rdv, cap);
    charge(5'h1F);
    rd_all(1, 6);
    $display("test gauge and status done");
    w(energy_cfg_pkg::ADDR_EWCFG, 8'h15);
    st(1'b0, 1'b1, 1'b0, 5'h09);
    chk_cfg();
    st(1'b0, 1'b1, 1'b0, 5'h08);
    #1;
    for (k = 0; k < 10 && readyPin_n !== 1'b0; k++) @(posedge core_clk) #1;
    for (n = 0; n < 40 && readyPin_n === 1'b0; n++) @(posedge core_clk) #1;
    chk("pulse", n, energy_cfg_pkg::EW_PULSE_DEFAULT);
    warn = 1;
    st(1'b1, 1'b0, 1'b0, 5'h14);
    chk_cfg();
    charge(5'h0C);
    chk_cfg();
    rd_all(1, 6);
    $display("test warning done");
    conclude();
  end
endmodule
